// [rtl/eeprom_read_consts.svh]
// Constants for the two-wire read-pointer block
`ifndef EEPROM_READ_CONSTS_SVH
`define EEPROM_READ_CONSTS_SVH
`define SCRATCH_ADDR_TOP 4'h8
`define CFG_EE_ADDR 7'h68
`define CFG_SRAM_ADDR 7'h69
`define BLK_CFG_EE 4'h8
`define BLK_CFG_SRAM 4'h9
`define BLK_SCRATCH_LAST 4'h7
`define WORD_LAST 8'hff
`define WORD_FIRST 8'h00
`define BIT_LAST 3'h7
`define SCL_DIV 8'h0a
`endif

// [rtl/eeprom_read_pkg.sv]
// Types shared by both ends of the two-wire read link
package eeprom_read_pkg;
   typedef logic [3:0] block_t;
   typedef logic [7:0] word_t;
   typedef enum logic [2:0] {
      CMD_NONE = 3'h0,
      CMD_CUR_READ = 3'h1,
      CMD_RAND_READ = 3'h2,
      CMD_WRITE_PTR = 3'h3
   } cmd_e;
endpackage

// [rtl/two_wire_if.sv]
// Two-wire link between the bus master and the memory slave
`timescale 1ns/1ns
`default_nettype none
interface two_wire_if;
   logic scl;
   logic sda_m_out;
   logic sda_m_oe_n;
   logic sda_s_out;
   logic sda_s_oe_n;
   wire serial_data_line = (!sda_m_oe_n && !sda_m_out) || (!sda_s_oe_n && !sda_s_out) ? 1'b0 : 1'b1;
   modport master (output scl, output sda_m_out, output sda_m_oe_n, input serial_data_line);
   modport slave (input scl, output sda_s_out, output sda_s_oe_n, input serial_data_line);
endinterface
`default_nettype wire

// [rtl/eeprom_read_slave.sv]
// Memory slave end: address decode, read pointer and byte shifter
`timescale 1ns/1ns
`default_nettype none
`include "eeprom_read_consts.svh"
module eeprom_read_slave #(
   parameter int DEPTH = 2560
) (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   two_wire_if.slave LINK,
   output logic [3:0] BLOCK,
   output logic [7:0] WORD
);
   import eeprom_read_pkg::*;

   typedef enum logic [5:0] {
      S_IDLE = 6'h01,
      S_ADDR = 6'h02,
      S_ACK = 6'h04,
      S_WADDR = 6'h08,
      S_SEND = 6'h10,
      S_MACK = 6'h20
   } state_e;

   logic [7:0] mem [0:DEPTH-1];
   logic scl_a, scl_s, scl_d, sda_a, sda_s, sda_d;
   state_e state;
   logic [2:0] cnt;
   logic [7:0] shreg;
   logic rd, have_waddr;
   block_t blk;
   word_t wrd;
   logic sda_o, sda_oe_n;

   ////////////////////////////////////////////////////////////////////
   assign LINK.sda_s_out = sda_o;
   assign LINK.sda_s_oe_n = sda_oe_n;
   wire scl_rise = scl_s && !scl_d;
   wire scl_fall = !scl_s && scl_d;
   wire start_c = scl_s && scl_d && sda_d && !sda_s;
   wire stop_c = scl_s && scl_d && !sda_d && sda_s;
   wire [7:0] addr_byte = {shreg[6:0], sda_s};
   wire is_scratch = addr_byte[7:4] == `SCRATCH_ADDR_TOP;
   wire is_cfg_ee = addr_byte[7:1] == `CFG_EE_ADDR;
   wire is_cfg_sram = addr_byte[7:1] == `CFG_SRAM_ADDR;
   wire hit = is_scratch || is_cfg_ee || is_cfg_sram;
   wire [3:0] addr_blk = is_scratch ? {1'b0, addr_byte[3:1]} :
      (is_cfg_ee ? `BLK_CFG_EE : `BLK_CFG_SRAM);

   // Scratch blocks chain, config blocks wrap on themselves
   function automatic logic [11:0] next_ptr(input logic [3:0] b, input logic [7:0] w);
      logic [3:0] nb;
      nb = b;
      if (w == `WORD_LAST && b <= `BLK_SCRATCH_LAST)
         nb = (b == `BLK_SCRATCH_LAST) ? 4'h0 : b + 4'h1;
      next_ptr = {nb, w + 8'h01};
   endfunction

   wire [11:0] incr = next_ptr(blk, wrd);
   wire [11:0] mem_idx = {blk, wrd};
   wire [7:0] rd_data = (mem_idx < DEPTH) ? mem[mem_idx] : 8'hff;

   ////////////////////////////////////////////////////////////////////
   // Pins cross into the core clock through two flops
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         {scl_a, scl_s, scl_d, sda_a, sda_s, sda_d} <= 6'h3f;
      end
      else
      begin
         {scl_a, scl_s, scl_d} <= {LINK.scl, scl_a, scl_s};
         {sda_a, sda_s, sda_d} <= {LINK.serial_data_line, sda_a, sda_s};
      end
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (state == S_WADDR && cnt == 3'h0 && have_waddr && scl_rise)
         mem[mem_idx] <= {shreg[6:0], sda_s};
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state <= S_IDLE;
         cnt <= 3'h0;
         shreg <= 8'h00;
         rd <= 1'b0;
         have_waddr <= 1'b0;
         blk <= 4'h0;
         wrd <= 8'h00;
         sda_o <= 1'b1;
         sda_oe_n <= 1'b1;
         BLOCK <= 4'h0;
         WORD <= 8'h00;
      end
      else
      begin
         BLOCK <= blk;
         WORD <= wrd;
         if (start_c)
         begin
            state <= S_ADDR;
            cnt <= `BIT_LAST;
            sda_oe_n <= 1'b1;
            have_waddr <= 1'b0;
         end
         else if (stop_c)
         begin
            state <= S_IDLE;
            sda_oe_n <= 1'b1;
         end
         else
         begin
            case (state)
               S_IDLE:
               begin
                  sda_oe_n <= 1'b1;
               end
               S_ADDR:
                  if (scl_rise)
                  begin
                     shreg <= addr_byte;
                     cnt <= cnt - 3'h1;
                     if (cnt == 3'h0)
                     begin
                        if (hit)
                        begin
                           rd <= sda_s;
                           blk <= addr_blk;
                           state <= S_ACK;
                        end
                        else
                           state <= S_IDLE;
                     end
                  end
               S_ACK:
                  if (scl_fall)
                  begin
                     if (sda_oe_n)
                     begin
                        sda_o <= 1'b0;
                        sda_oe_n <= 1'b0;
                     end
                     else if (rd)
                     begin
                        sda_o <= rd_data[7];
                        shreg <= {rd_data[6:0], 1'b0};
                        cnt <= `BIT_LAST;
                        state <= S_SEND;
                     end
                     else
                     begin
                        sda_oe_n <= 1'b1;
                        cnt <= `BIT_LAST;
                        state <= S_WADDR;
                     end
                  end
               S_WADDR:
                  if (scl_rise)
                  begin
                     shreg <= {shreg[6:0], sda_s};
                     cnt <= cnt - 3'h1;
                     if (cnt == 3'h0)
                     begin
                        if (!have_waddr)
                           wrd <= {shreg[6:0], sda_s};
                        else
                           {blk, wrd} <= incr;
                        have_waddr <= 1'b1;
                        state <= S_ACK;
                     end
                  end
               S_SEND:
                  if (scl_fall)
                  begin
                     if (cnt == 3'h1)
                        {blk, wrd} <= incr;
                     if (cnt == 3'h0)
                     begin
                        sda_oe_n <= 1'b1;
                        state <= S_MACK;
                     end
                     else
                     begin
                        sda_o <= shreg[7];
                        shreg <= {shreg[6:0], 1'b0};
                        cnt <= cnt - 3'h1;
                     end
                  end
               S_MACK:
                  if (scl_rise && sda_s)
                     state <= S_IDLE;
                  else if (scl_fall)
                  begin
                     sda_o <= rd_data[7];
                     sda_oe_n <= 1'b0;
                     shreg <= {rd_data[6:0], 1'b0};
                     cnt <= `BIT_LAST;
                     state <= S_SEND;
                  end
               default:
                  state <= S_IDLE;
            endcase
         end
      end
   end
   // Master ack leads straight into the next byte, no slave ack slot
endmodule // eeprom_read_slave
`default_nettype wire

// [rtl/eeprom_read_master.sv]
// Bus master end: issues pointer writes and multi-byte reads
`timescale 1ns/1ns
`default_nettype none
`include "eeprom_read_consts.svh"
module eeprom_read_master (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   two_wire_if.master LINK,
   input wire eeprom_read_pkg::cmd_e CMD,
   input wire logic [6:0] DEV,
   input wire logic [7:0] WADDR,
   input wire logic [7:0] COUNT,
   output logic BUSY,
   output logic DATA_VALID,
   output logic [7:0] DATA,
   output logic NACK
);
   import eeprom_read_pkg::*;

   typedef enum logic [4:0] {
      M_IDLE = 5'h01,
      M_START = 5'h02,
      M_BIT = 5'h04,
      M_STOP = 5'h08,
      M_DONE = 5'h10
   } mstate_e;

   mstate_e st;
   logic [7:0] div;
   logic [1:0] ph;
   logic [3:0] bitn;
   logic [8:0] sh;
   logic [1:0] seg;
   logic [7:0] left;
   cmd_e cmd;
   logic sda_a, sda_s;
   logic scl_o, sda_o;

   ////////////////////////////////////////////////////////////////////
   assign LINK.scl = scl_o;
   assign LINK.sda_m_out = sda_o;
   // Open drain: a one releases the line
   assign LINK.sda_m_oe_n = sda_o;
   wire tick = div == `SCL_DIV;
   // Segments: 0 write addr, 1 word addr, 2 read addr, 3 data
   wire reading = seg == 2'h3;
   wire [8:0] rd_ctl = {DEV, 1'b1, 1'b1};
   wire last_byte = left == 8'h01;
   // Ack slot of the following byte is armed when this one completes
   wire next_last = left == 8'h02;

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         sda_a <= 1'b1;
         sda_s <= 1'b1;
      end
      else
      begin
         sda_a <= LINK.serial_data_line;
         sda_s <= sda_a;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         st <= M_IDLE;
         div <= 8'h00;
         ph <= 2'h0;
         bitn <= 4'h0;
         sh <= 9'h1ff;
         seg <= 2'h0;
         left <= 8'h00;
         cmd <= CMD_NONE;
         scl_o <= 1'b1;
         sda_o <= 1'b1;
         BUSY <= 1'b0;
         DATA_VALID <= 1'b0;
         DATA <= 8'h00;
         NACK <= 1'b0;
      end
      else
      begin
         DATA_VALID <= 1'b0;
         div <= tick ? 8'h00 : div + 8'h01;
         case (st)
            M_IDLE:
               if (CMD != CMD_NONE)
               begin
                  cmd <= CMD;
                  // Pointer writes may carry no data bytes at all
                  left <= (COUNT == 8'h00 && CMD != CMD_WRITE_PTR) ? 8'h01 : COUNT;
                  seg <= (CMD == CMD_CUR_READ) ? 2'h2 : 2'h0;
                  BUSY <= 1'b1;
                  NACK <= 1'b0;
                  ph <= 2'h0;
                  st <= M_START;
               end
            M_START:
               if (tick)
               begin
                  ph <= ph + 2'h1;
                  if (ph == 2'h0)
                  begin
                     scl_o <= 1'b1;
                     sda_o <= 1'b1;
                  end
                  else if (ph == 2'h1)
                     sda_o <= 1'b0;
                  else if (ph == 2'h2)
                  begin
                     scl_o <= 1'b0;
                     sh <= (seg == 2'h2) ? rd_ctl : {DEV, 1'b0, 1'b1};
                     bitn <= 4'h0;
                     ph <= 2'h0;
                     st <= M_BIT;
                  end
               end
            M_BIT:
               if (tick)
               begin
                  ph <= ph + 2'h1;
                  if (ph == 2'h0)
                     sda_o <= sh[8];
                  else if (ph == 2'h1)
                     scl_o <= 1'b1;
                  else if (ph == 2'h2)
                     sh <= {sh[7:0], sda_s};
                  else
                  begin
                     scl_o <= 1'b0;
                     bitn <= bitn + 4'h1;
                     if (bitn == 4'h8)
                     begin
                        bitn <= 4'h0;
                        if (reading)
                        begin
                           DATA <= sh[8:1];
                           DATA_VALID <= 1'b1;
                           left <= left - 8'h01;
                           if (last_byte)
                              st <= M_STOP;
                           else
                              sh <= {8'hff, next_last};
                        end
                        else if (sh[0])
                        begin
                           NACK <= 1'b1;
                           st <= M_STOP;
                        end
                        else if (seg == 2'h0)
                        begin
                           seg <= 2'h1;
                           sh <= {WADDR, 1'b1};
                        end
                        else if (seg == 2'h1 && cmd == CMD_WRITE_PTR && left != 8'h00)
                        begin
                           // Data bytes repeat the word address value
                           left <= left - 8'h01;
                           sh <= {WADDR, 1'b1};
                        end
                        else if (seg == 2'h1)
                        begin
                           seg <= 2'h2;
                           st <= (cmd == CMD_WRITE_PTR) ? M_STOP : M_START;
                        end
                        else
                        begin
                           seg <= 2'h3;
                           sh <= {8'hff, !last_byte ? 1'b0 : 1'b1};
                        end
                     end
                  end
               end
            M_STOP:
               if (tick)
               begin
                  ph <= ph + 2'h1;
                  if (ph == 2'h0)
                     sda_o <= 1'b0;
                  else if (ph == 2'h1)
                     scl_o <= 1'b1;
                  else if (ph == 2'h2)
                  begin
                     sda_o <= 1'b1;
                     ph <= 2'h0;
                     st <= M_DONE;
                  end
               end
            M_DONE:
            begin
               BUSY <= 1'b0;
               st <= M_IDLE;
            end
            default:
               st <= M_IDLE;
         endcase
      end
   end
endmodule // eeprom_read_master
`default_nettype wire

// [sim/eeprom_read_link_sva.sv]
// Checker for the two-wire link between master and memory slave
`timescale 1ns/1ns
`default_nettype none
module eeprom_read_link_sva (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic scl,
   input wire logic sda_m_out,
   input wire logic sda_m_oe_n,
   input wire logic sda_s_out,
   input wire logic sda_s_oe_n,
   input wire logic serial_data_line
);
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_N);
   ////////////////////////////////////////////////////////////////////////////
   // Length of one unbroken slave drive; ack plus eight data bits fit well below
   logic [15:0] drive_cnt;
   logic [15:0] next_drive_cnt;
   assign next_drive_cnt = sda_s_oe_n ? 16'h0000 : drive_cnt + 16'h0001;
   always_ff @(posedge CORE_CLK or negedge RST_N)
   begin
      if (!RST_N)
         drive_cnt <= 16'h0000;
      else
         drive_cnt <= next_drive_cnt;
   end
   sequence start_seen;
      $fell(serial_data_line) && scl && $past(scl);
   endsequence
   sequence stop_seen;
      $rose(serial_data_line) && scl && $past(scl);
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   a_start_quiet: assert property (start_seen |-> sda_s_oe_n [*8])
      else $error("slave drives line right after start");
   a_stop_quiet: assert property (stop_seen |-> sda_s_oe_n [*8])
      else $error("slave drives line at or after stop");
   a_oe_stable_high: assert property (
      scl && $past(scl) && $past(scl, 2) && $past(scl, 3) |-> $stable(sda_s_oe_n))
      else $error("slave enable moves while clock high");
   a_out_stable_high: assert property (
      scl && $past(scl, 3) && !sda_s_oe_n && $past(!sda_s_oe_n) |-> $stable(sda_s_out))
      else $error("slave data moves while clock high");
   a_drive_starts_low: assert property ($fell(sda_s_oe_n) |-> !scl)
      else $error("slave starts driving while clock high");
   a_release_clock_low: assert property ($rose(sda_s_oe_n) |-> !scl)
      else $error("slave releases while clock high");
   a_drive_bounded: assert property (drive_cnt <= 16'h01c2)
      else $error("slave holds line too long");
   a_scl_high_width: assert property ($rose(scl) |-> scl [*8])
      else $error("clock high phase too short");
   ////////////////////////////////////////////////////////////////////////////
   c_start: cover property (start_seen);
   c_stop: cover property (stop_seen);
   c_slave_sends: cover property ($fell(sda_s_oe_n) ##[1:500] $rose(sda_s_oe_n));
endmodule // eeprom_read_link_sva
`default_nettype wire

// [sim/eeprom_i2c_read_pointer_tb.sv]
// Testbench: master and slave joined, pointer moves checked at the slave
`timescale 1ns/1ns
`default_nettype none
module eeprom_i2c_read_pointer_tb;
   import eeprom_read_pkg::*;
   logic CORE_CLK;
   logic RST_N;
   cmd_e cmd;
   logic [6:0] dev;
   logic [7:0] waddr;
   logic [7:0] count;
   logic busy;
   logic data_valid;
   logic [7:0] data;
   logic nack;
   logic [3:0] block;
   logic [7:0] word;
   int failures;
   int n_tests;
   int nb;
   two_wire_if link();
   eeprom_read_slave #(.DEPTH(2560)) i_eeprom_read_slave (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
      .LINK(link), .BLOCK(block), .WORD(word));
   eeprom_read_master i_eeprom_read_master (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .LINK(link),
      .CMD(cmd), .DEV(dev), .WADDR(waddr), .COUNT(count), .BUSY(busy),
      .DATA_VALID(data_valid), .DATA(data), .NACK(nack));
   eeprom_read_link_sva i_eeprom_read_link_sva (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
      .scl(link.scl), .sda_m_out(link.sda_m_out), .sda_m_oe_n(link.sda_m_oe_n),
      .sda_s_out(link.sda_s_out), .sda_s_oe_n(link.sda_s_oe_n),
      .serial_data_line(link.serial_data_line));
   always #50 CORE_CLK = ~CORE_CLK;
   ////////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One transfer; counts data pulses, bounded so a hung link ends the run
   task automatic do_cmd(input cmd_e c, input logic [6:0] d, input logic [7:0] w,
      input logic [7:0] n);
      int i;
      nb = 0;
      @(negedge CORE_CLK);
      cmd = c;
      dev = d;
      waddr = w;
      count = n;
      @(negedge CORE_CLK);
      cmd = CMD_NONE;
      for (i = 0; i < 20000 && busy !== 1'b0; i++)
      begin
         @(negedge CORE_CLK);
         if (data_valid === 1'b1)
            nb++;
      end
      if (i == 20000)
      begin
         failures++;
         complete_run();
      end
   endtask
   task automatic expect_ptr(input logic [3:0] b, input logic [7:0] w, input logic [7:0] bytes);
      check({4'h0, block}, {4'h0, b});
      check(word, w);
      check(8'(nb), bytes);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_ptr_write;
      do_cmd(CMD_WRITE_PTR, 7'h68, 8'hfe, 8'h00);
      check({7'h00, nack}, 8'h00);
      expect_ptr(4'h8, 8'hfe, 8'h00);
   endtask
   task automatic t_cfg_wrap;
      do_cmd(CMD_CUR_READ, 7'h68, 8'h00, 8'h03);
      check({7'h00, nack}, 8'h00);
      expect_ptr(4'h8, 8'h01, 8'h03);
   endtask
   task automatic t_scratch_wrap;
      do_cmd(CMD_RAND_READ, 7'h47, 8'hff, 8'h02);
      expect_ptr(4'h0, 8'h01, 8'h02);
   endtask
   task automatic t_block_step;
      int s;
      for (s = 0; s < 7; s++)
      begin
         do_cmd(CMD_RAND_READ, 7'h40 | 7'(s), 8'hff, 8'h01);
         expect_ptr(4'(s + 1), 8'h00, 8'h01);
      end
   endtask
   task automatic t_sram_wrap;
      do_cmd(CMD_RAND_READ, 7'h69, 8'hff, 8'h02);
      expect_ptr(4'h9, 8'h01, 8'h02);
   endtask
   // Foreign address: no ack, pointer must not move
   task automatic t_foreign;
      do_cmd(CMD_CUR_READ, 7'h50, 8'h00, 8'h01);
      check({7'h00, nack}, 8'h01);
      expect_ptr(4'h9, 8'h01, 8'h00);
   endtask
   // Two stored bytes read back singly, by current address and in sequence
   task automatic t_write_back;
      do_cmd(CMD_WRITE_PTR, 7'h40, 8'h5a, 8'h01);
      do_cmd(CMD_WRITE_PTR, 7'h40, 8'h5b, 8'h01);
      check({7'h00, nack}, 8'h00);
      expect_ptr(4'h0, 8'h5c, 8'h00);
      do_cmd(CMD_RAND_READ, 7'h40, 8'h5a, 8'h01);
      check(data, 8'h5a);
      do_cmd(CMD_CUR_READ, 7'h40, 8'h00, 8'h01);
      check(data, 8'h5b);
      do_cmd(CMD_RAND_READ, 7'h40, 8'h5a, 8'h02);
      check(data, 8'h5b);
      expect_ptr(4'h0, 8'h5c, 8'h02);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      CORE_CLK = 1'b0;
      RST_N = 1'b0;
      cmd = CMD_NONE;
      dev = 7'h00;
      waddr = 8'h00;
      count = 8'h00;
      failures = 0;
      n_tests = 0;
      repeat (3) @(negedge CORE_CLK);
      RST_N = 1'b1;
      t_ptr_write();
      t_cfg_wrap();
      t_scratch_wrap();
      t_block_step();
      t_sram_wrap();
      t_foreign();
      t_write_back();
      complete_run();
   end
endmodule // eeprom_i2c_read_pointer_tb
`default_nettype wire
